// *** dv/jsid_plc.sv ***
`default_nettype none
module jsid_plc (
  input wire logic aclk,
  output logic [7:0] din,
  output logic trig
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulse widths are the 5 ms high and 5 ms low, scaled to cycles below the gap.
  localparam int PULSE_CYC = 5;

  initial begin
    din = 8'h00;
    trig = 1'b0;
  end

  // Every select line moves at one edge, so no halfway pattern is ever seen.
  task automatic set_pattern(input logic [7:0] v);
    din <= v;
  endtask

  task automatic pulses(input int k, input int n);
    repeat (n) begin
      din[k] <= 1'b1;
      repeat (PULSE_CYC) @(posedge aclk);
      din[k] <= 1'b0;
      repeat (PULSE_CYC) @(posedge aclk);
    end
  endtask

  // Only called once software has reported the change complete.
  task automatic fire();
    trig <= 1'b1;
    repeat (3) @(posedge aclk);
    trig <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// *** dv/jsid_top_test.sv ***
`default_nettype none
module jsid_top_test import jsid_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP_N = 20;
  localparam int CONF_N = 5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, ready_o, confirm_o, job_chg_o, trig;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NIN-1:0] din;
  logic [JOBW-1:0] run_job_o;
  logic [4:0] pat [4] = '{5'h1f, 5'h0a, 5'h01, 5'h10};
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  always #10 aclk = ~aclk;

  jsid_top #(.GAP_CYCLES(TMRW'(GAP_N)), .CONF_CYCLES(TMRW'(CONF_N))) u_jsid_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .din(din), .trig(trig),
    .ready_o(ready_o), .confirm_o(confirm_o), .run_job_o(run_job_o), .job_chg_o(job_chg_o)
  );

  jsid_plc u_jsid_plc (.aclk(aclk), .din(din), .trig(trig));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Both response readies stay high, so the answer is taken at the edge it is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (bvalid) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rvalid) break;
      if (arready) arvalid <= 1'b0;
    end
    chk("rdata", e, rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic chk_job(input logic [4:0] e);
    chk("run_job", {27'h0, e}, {27'h0, run_job_o});
  endtask

  initial begin
    wait_cyc(6);
    aresetn <= 1'b1;
    wait_cyc(3);
    chk("ready", 32'h1, {31'h0, ready_o});
    chk_job(5'h01);
    rd(OFS_STAT, 32'h0100_0001, 32'h0100_001f, RESP_OKAY);
    rd(OFS_FUNC, FUNC_RST, 32'hffff_ffff, RESP_OKAY);
    rd(8'h14, 32'h0, 32'hffff_ffff, RESP_SLVERR);
    wr(8'h18, 32'h1, RESP_SLVERR);
    // Job memory is wiped by a load.
    wr(OFS_JADR, 32'h0, RESP_OKAY);
    wr(OFS_JDAT, 32'hdead_beef, RESP_OKAY);
    wr(OFS_JDAT, 32'h1234_5678, RESP_OKAY);
    wr(OFS_JADR, 32'h1, RESP_OKAY);
    rd(OFS_JDAT, 32'h1234_5678, 32'hffff_ffff, RESP_OKAY);
    wr(OFS_CTRL, 32'h2, RESP_OKAY);
    rd(OFS_JADR, 32'h0, 32'h1f, RESP_OKAY);
    rd(OFS_JDAT, 32'h0, 32'hffff_ffff, RESP_OKAY);
    wr(OFS_JADR, 32'h1, RESP_OKAY);
    rd(OFS_JDAT, 32'h0, 32'hffff_ffff, RESP_OKAY);
    // Two-job level on two different inputs.
    for (int k = 0; k < 8; k += 5) begin
      wr(OFS_FUNC, 32'h1 << (4 * k), RESP_OKAY);
      u_jsid_plc.set_pattern(8'h1 << k);
      wait_cyc(4);
      chk_job(JOB_SECOND);
      u_jsid_plc.set_pattern(8'h0);
      wait_cyc(4);
      chk_job(JOB_RST);
    end
    // Binary code on inputs 3 to 7.
    wr(OFS_FUNC, 32'h7654_3000, RESP_OKAY);
    foreach (pat[i]) begin
      u_jsid_plc.set_pattern({pat[i], 3'h0});
      n = 0;
      repeat (6) begin
        wait_cyc(1);
        n += int'(job_chg_o);
      end
      chk("job_chg", 32'h1, n);
      chk_job(pat[i]);
    end
    u_jsid_plc.set_pattern(8'h0);
    wait_cyc(6);
    chk_job(5'h10);
    rd(OFS_STAT, 32'h0000_0100, 32'h0000_1f00, RESP_OKAY);
    wr(OFS_CTRL, 32'h4, RESP_OKAY);
    u_jsid_plc.fire();
    wait_cyc(4);
    rd(OFS_STAT, 32'h0000_1000, 32'h0000_1f00, RESP_OKAY);
    // Pulse count with confirmation.
    wr(OFS_FUNC, 32'h0000_0200, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    u_jsid_plc.pulses(2, 3);
    wait_cyc(GAP_N - 8);
    chk("ready_early", 32'h1, {31'h0, ready_o});
    n = 0;
    while (ready_o !== 1'b0 && n < 12) begin
      wait_cyc(1);
      n++;
    end
    chk("ready_low", 32'h0, {31'h0, ready_o});
    chk_job(5'h03);
    u_jsid_plc.pulses(2, 2);
    wait_cyc(GAP_N + 5);
    chk("ready_held", 32'h0, {31'h0, ready_o});
    wr(OFS_CTRL, 32'h5, RESP_OKAY);
    n = 0;
    while (confirm_o !== 1'b1 && n < 10) begin
      wait_cyc(1);
      n++;
    end
    n = 0;
    while (confirm_o === 1'b1 && n < 50) begin
      chk("ready_conf", 32'h0, {31'h0, ready_o});
      wait_cyc(1);
      n++;
    end
    chk("conf_len", CONF_N, n);
    chk("ready_back", 32'h1, {31'h0, ready_o});
    wait_cyc(GAP_N + 5);
    chk_job(5'h03);
    // Count beyond the top job number, no confirmation.
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    u_jsid_plc.pulses(2, 33);
    n = 0;
    while (ready_o !== 1'b0 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    chk("ready_sat", 32'h0, {31'h0, ready_o});
    chk_job(JOB_MAX);
    wr(OFS_CTRL, 32'h4, RESP_OKAY);
    wait_cyc(2);
    chk("ready_done", 32'h1, {31'h0, ready_o});
    chk("confirm_off", 32'h0, {31'h0, confirm_o});
    stop_test();
  end
endmodule
`default_nettype wire

// *** rtl/jsid_pkg.sv ***
`default_nettype none
package jsid_pkg;
  localparam int NIN = 8;
  localparam int JOBW = 5;
  localparam int NJOB = 32;
  localparam int TMRW = 22;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FUNC = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_JADR = 8'h0c;
  localparam logic [7:0] OFS_JDAT = 8'h10;
  localparam int CTRL_CONF_BIT = 0;
  localparam int CTRL_LOAD_BIT = 1;
  localparam int CTRL_DONE_BIT = 2;
  localparam logic CONF_EN_RST = 1'b0;
  localparam logic [31:0] FUNC_RST = 32'h0000_0000;
  localparam logic [JOBW-1:0] JOB_RST = 5'h01;
  localparam logic [JOBW-1:0] JOB_SECOND = 5'h02;
  localparam logic [JOBW-1:0] JOB_MAX = 5'h1f;
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_TWO = 4'h1;
  localparam logic [3:0] FN_PULSE = 4'h2;
  localparam logic [3:0] FN_BIT0 = 4'h3;
  localparam int CLK_HZ = 50_000_000;
  localparam int GAP_MS = 50;
  localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
  localparam int CONF_MS = 10;
  localparam int CONF_CYC = CLK_HZ / 1000 * CONF_MS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_COUNT = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_CONF = 4'b1000
  } jsid_state_t;

  typedef struct packed {
    logic [3:0] rsv3;
    logic pend;
    logic conf;
    logic busy;
    logic ready;
    logic [2:0] rsv2;
    logic [JOBW-1:0] cnt;
    logic [2:0] rsv1;
    logic [JOBW-1:0] disp;
    logic [2:0] rsv0;
    logic [JOBW-1:0] run;
  } jsid_stat_t;
endpackage
`default_nettype wire

// *** rtl/jsid_sync.sv ***
`default_nettype none
module jsid_sync import jsid_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_r[i] <= 1'b0;
        q_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= d[i];
        q_r[i] <= meta_r[i];
      end
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// *** rtl/jsid_top.sv ***
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`default_nettype none
module jsid_top import jsid_pkg::*; #(
  parameter logic [TMRW-1:0] GAP_CYCLES = TMRW'(GAP_CYC),
  parameter logic [TMRW-1:0] CONF_CYCLES = TMRW'(CONF_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [NIN-1:0] din,
  input wire logic trig,
  output logic ready_o,
  output logic confirm_o,
  output logic [JOBW-1:0] run_job_o,
  output logic job_chg_o
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_got_r, w_got_r;
  logic wr_fire, wr_ok, rd_ok, load_w, done_w;
  logic [31:0] rd_word;
  logic conf_en_r;
  logic [31:0] func_r;
  logic [JOBW-1:0] jadr_r;
  logic [31:0] jmem [NJOB];
  logic [NIN:0] sync_q;
  logic [NIN-1:0] s_din;
  logic s_trig, trig_prev_r, trig_rise;
  logic [NIN-1:0] two_sel, pls_sel, bsel;
  logic [NIN-1:0] bhit [JOBW];
  logic [JOBW-1:0] bin_pat, bin_prev_r, two_job;
  logic two_any, two_lvl, two_prev_r, bin_any, pulse_in, p_prev_r, p_rise;
  logic bin_req, two_req, gap_hit, chg_any;
  jsid_state_t st_r;
  logic [JOBW-1:0] cnt_r, run_r, disp_r;
  logic [TMRW-1:0] tmr_r;
  logic ready_r, conf_r, busy_r, pend_r, job_chg_r;
  jsid_stat_t stat;

  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign ready_o = ready_r;
  assign confirm_o = conf_r;
  assign run_job_o = run_r;
  assign job_chg_o = job_chg_r;

  // Address and data are latched separately so either may arrive first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else begin
      if (awvalid && awready_r) begin
        aw_addr_r <= awaddr;
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wr_ok = (aw_addr_r <= OFS_JDAT) && (aw_addr_r[1:0] == 2'h0);
  assign load_w = wr_fire && aw_addr_r == OFS_CTRL && w_strb_r[0]
                  && w_data_r[CTRL_LOAD_BIT];
  assign done_w = wr_fire && aw_addr_r == OFS_CTRL && w_strb_r[0]
                  && w_data_r[CTRL_DONE_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conf_en_r <= CONF_EN_RST;
      func_r <= FUNC_RST;
      jadr_r <= 5'h00;
    end else if (wr_fire) begin
      if (aw_addr_r == OFS_CTRL && w_strb_r[0]) begin
        conf_en_r <= w_data_r[CTRL_CONF_BIT];
      end
      if (aw_addr_r == OFS_FUNC) begin
        func_r <= wmask(func_r, w_data_r, w_strb_r);
      end
      if (aw_addr_r == OFS_JADR && w_strb_r[0]) begin
        jadr_r <= w_data_r[JOBW-1:0];
      end
      if (aw_addr_r == OFS_JDAT) begin
        jadr_r <= jadr_r + 5'h01;
      end
      if (load_w) begin
        jadr_r <= 5'h00;
      end
    end
  end

  // A job-set load wipes every entry in one cycle, so no stale job survives.
  always_ff @(posedge aclk) begin
    if (!aresetn || load_w) begin
      for (int i = 0; i < NJOB; i++) begin
        jmem[i] <= 32'h0;
      end
    end else if (wr_fire && aw_addr_r == OFS_JDAT) begin
      jmem[jadr_r] <= wmask(jmem[jadr_r], w_data_r, w_strb_r);
    end
  end

  always_comb begin
    stat = '0;
    stat.pend = pend_r;
    stat.conf = conf_r;
    stat.busy = busy_r;
    stat.ready = ready_r;
    stat.cnt = cnt_r;
    stat.disp = disp_r;
    stat.run = run_r;
  end

  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    case (araddr)
      OFS_CTRL: rd_word = {31'h0, conf_en_r};
      OFS_FUNC: rd_word = func_r;
      OFS_STAT: rd_word = stat;
      OFS_JADR: rd_word = {27'h0, jadr_r};
      OFS_JDAT: rd_word = jmem[jadr_r];
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  jsid_sync #(
    .W(NIN + 1)
  ) u_jsid_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({trig, din}),
    .q(sync_q)
  );

  assign s_din = sync_q[NIN-1:0];
  assign s_trig = sync_q[NIN];

  // Each input picks its own function from a four-bit field of the map.
  for (genvar k = 0; k < NIN; k++) begin : g_in
    logic [3:0] fn;
    assign fn = func_r[4*k +: 4];
    assign two_sel[k] = (fn == FN_TWO);
    assign pls_sel[k] = (fn == FN_PULSE);
    assign bsel[k] = (fn >= FN_BIT0) && (fn < FN_BIT0 + 4'(JOBW));
    for (genvar b = 0; b < JOBW; b++) begin : g_bit
      assign bhit[b][k] = (fn == FN_BIT0 + 4'(b)) && s_din[k];
    end
  end

  for (genvar b = 0; b < JOBW; b++) begin : g_pat
    assign bin_pat[b] = |bhit[b];
  end

  assign two_any = |two_sel;
  assign two_lvl = |(two_sel & s_din);
  assign two_job = two_lvl ? JOB_SECOND : JOB_RST;
  assign bin_any = |bsel;
  assign pulse_in = |(pls_sel & s_din);
  assign p_rise = pulse_in && !p_prev_r;
  assign trig_rise = s_trig && !trig_prev_r;
  // Controller presents all binary bits together, so any change to a nonzero pattern is a real request.
  assign bin_req = bin_any && bin_pat != bin_prev_r && bin_pat != 5'h00;
  assign two_req = two_any && !bin_any && two_lvl != two_prev_r;
  assign gap_hit = st_r == ST_COUNT && !pulse_in && tmr_r == GAP_CYCLES - 1'b1;
  assign chg_any = bin_req || two_req || gap_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bin_prev_r <= 5'h00;
      two_prev_r <= 1'b0;
      p_prev_r <= 1'b0;
      trig_prev_r <= 1'b0;
    end else begin
      bin_prev_r <= bin_pat;
      two_prev_r <= two_any ? two_lvl : 1'b0;
      p_prev_r <= pulse_in;
      trig_prev_r <= s_trig;
    end
  end

  // Binary wins over two-job, which wins over a finished pulse count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= JOB_RST;
      job_chg_r <= 1'b0;
    end else begin
      job_chg_r <= chg_any;
      if (bin_req) begin
        run_r <= bin_pat;
      end else if (two_req) begin
        run_r <= two_job;
      end else if (gap_hit) begin
        run_r <= cnt_r;
      end
    end
  end

  // A new change in the same cycle as the clearing event keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      disp_r <= JOB_RST;
    end else begin
      if (chg_any) begin
        busy_r <= 1'b1;
      end else if (done_w) begin
        busy_r <= 1'b0;
      end
      if (chg_any) begin
        pend_r <= 1'b1;
      end else if (trig_rise) begin
        pend_r <= 1'b0;
      end
      if (trig_rise && pend_r) begin
        disp_r <= run_r;
      end
    end
  end

  // Pulses only advance the count in states where ready is high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 5'h00;
      tmr_r <= '0;
      ready_r <= 1'b1;
      conf_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (p_rise) begin
            cnt_r <= 5'h01;
            tmr_r <= '0;
            st_r <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (p_rise) begin
            if (cnt_r != JOB_MAX) begin
              cnt_r <= cnt_r + 5'h01;
            end
            tmr_r <= '0;
          end else if (pulse_in) begin
            tmr_r <= '0;
          end else if (gap_hit) begin
            ready_r <= 1'b0;
            st_r <= ST_WAIT;
          end else begin
            tmr_r <= tmr_r + 1'b1;
          end
        end
        ST_WAIT: begin
          if (done_w) begin
            tmr_r <= '0;
            if (conf_en_r) begin
              conf_r <= 1'b1;
              st_r <= ST_CONF;
            end else begin
              ready_r <= 1'b1;
              st_r <= ST_IDLE;
            end
          end
        end
        ST_CONF: begin
          if (tmr_r == CONF_CYCLES - 1'b1) begin
            conf_r <= 1'b0;
            ready_r <= 1'b1;
            st_r <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r + 1'b1;
          end
        end
        default: begin
          st_r <= ST_IDLE;
          ready_r <= 1'b1;
          conf_r <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_two_job_level: assert property (two_req && !bin_req |=> run_r == $past(two_job))
    else $error("two-job level not applied");
  a_bin_decode: assert property (bin_req |=> run_r == $past(bin_pat))
    else $error("binary pattern not decoded");
  a_bin_immediate: assert property (bin_any && bin_pat != bin_prev_r && bin_pat != 5'h00
    |=> job_chg_r && busy_r)
    else $error("binary change not started at once");
  a_disp_on_trig: assert property ($changed(disp_r) |-> $past(trig_rise && pend_r))
    else $error("active job display moved without trigger");
  a_func_write: assert property (wr_fire && aw_addr_r == OFS_FUNC && w_strb_r == 4'hf
    |=> func_r == $past(w_data_r))
    else $error("input function map not stored");
  a_pulse_ignored: assert property (!ready_r |=> $stable(cnt_r))
    else $error("pulse counted while not ready");
  a_gap_switch: assert property (gap_hit && !bin_req && !two_req
    |=> run_r == $past(cnt_r) && job_chg_r)
    else $error("pulse count not selected after gap");
  a_ready_drop: assert property (gap_hit |=> !ready_r && st_r == ST_WAIT)
    else $error("ready not dropped after gap");
  a_ready_hold: assert property (st_r == ST_WAIT && !done_w |=> !ready_r)
    else $error("ready rose before switch done");
  a_conf_first: assert property (st_r == ST_WAIT && done_w && conf_en_r
    |=> conf_r && !ready_r)
    else $error("confirm not shown before ready");
  a_load_erase: assert property (load_w |=> jmem[0] == 32'h0 && jmem[NJOB-1] == 32'h0)
    else $error("job memory not erased on load");
  a_zero_none: assert property (bin_any && bin_pat == 5'h00 && !two_req && !gap_hit
    |=> !job_chg_r)
    else $error("zero pattern caused a job change");

  c_pulse_switch: cover property (gap_hit);
  c_confirm_done: cover property (st_r == ST_CONF ##1 st_r == ST_IDLE);
  c_bin_change: cover property (bin_req);
  c_disp_update: cover property (trig_rise && pend_r);
endmodule
`default_nettype wire
